// *** logic/flgp_gate_pattern_gen.sv ***
`timescale 1ns/1ps
`include "flgp_cfg.svh"

// ****************
// Five-level gate pattern generator
// ****************

// Summary of operation
// - All six bridge gates from three signals or complements
// - Polarity toggles each half of 60 Hz
// - Cell PWM rate configurable, 16 to 20 kHz
// - Series low-frequency pair shares one pulse
// - Two legs run 180 degrees apart
// - Output ripple at twice the switching rate
// - Three-bit state code sets output level
// - Eight states map onto five levels
// - Alternate redundant states to balance capacitors
// - State 110 charges, 101 discharges capacitors
// - State 010 discharges the flying capacitors
// - State 001 charges the flying capacitors
// - States 111,100,011,000 bypass the capacitors
// - Drive inrush bypass switch across resistor
// - Stop on input under or overvoltage
// - Stop on output overload or short
// - Reach nominal output within 500 ms
// - Cells compare one value to shifted carriers
module flgp_gate_pattern_gen #(
    // Cycles per polarity half-cycle.
    parameter int unsigned LINE_HALF_CYC =
        `FLGP_CLK_HZ / (`FLGP_HALVES * `FLGP_LINE_HZ),
    // Precharge time through the inrush resistor, in cycles.
    parameter int unsigned PRECHARGE_CYC =
        (`FLGP_CLK_HZ / `FLGP_MS_PER_S) * `FLGP_PRECHARGE_MS,
    // Cycles per soft-start gain step.
    parameter int unsigned RAMP_STEP_CYC =
        (`FLGP_CLK_HZ / `FLGP_MS_PER_S) * `FLGP_RAMP_MS / `FLGP_GAIN_FULL,
    // Longest start-up time, in cycles.
    parameter int unsigned STARTUP_CYC =
        (`FLGP_CLK_HZ / `FLGP_MS_PER_S) * `FLGP_STARTUP_MS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Control.
    input wire logic runEnable,
    input wire logic faultClear,
    input wire logic [`FLGP_CAR_W-1:0] dutyMag,
    input wire logic [`FLGP_CAR_W-1:0] swHalfPeriod,
    input wire logic [`FLGP_DT_W-1:0] deadTime,
    // Protection comparators.
    input wire logic inputUndervoltTrip,
    input wire logic inputOvervoltTrip,
    input wire logic outputOverloadTrip,
    input wire logic outputShortTrip,
    // Gate drives.
    output logic linePolarityPwm,
    output logic linePolarityPwmN,
    output logic hfCellOnePwm,
    output logic hfCellOnePwmN,
    output logic hfCellTwoPwm,
    output logic hfCellTwoPwmN,
    output logic inrushBypassSwitch,
    // Status.
    output logic [2:0] switchState,
    output logic [2:0] outputLevel,
    output logic capCharging,
    output logic capDischarging,
    output logic capBypassed,
    output logic startupDone,
    output logic faultLatched,
    output logic [`FLGP_NFAULT-1:0] faultCause
);

    // ****************
    // Declarations
    // ****************

    localparam int TW = `FLGP_TMR_W;
    localparam int CW = `FLGP_CAR_W;
    localparam int GW = `FLGP_GAIN_W;
    localparam int PW = CW + GW;
    localparam logic [TW-1:0] LINE_LAST = TW'(LINE_HALF_CYC - 1);
    localparam logic [TW-1:0] PRE_LAST = TW'(PRECHARGE_CYC - 1);
    localparam logic [TW-1:0] STEP_LAST = TW'(RAMP_STEP_CYC - 1);
    localparam logic [TW-1:0] START_LAST = TW'(STARTUP_CYC - 1);

    flgp_pkg::flgp_state_t state_q; // Sequencer state.
    flgp_pkg::flgp_state_t state_d; // Next sequencer state.
    logic [TW-1:0] lineCnt_q; // Polarity half-cycle timer.
    logic polarity_q; // Requested polarity level.
    logic [TW-1:0] seqCnt_q; // Precharge and ramp step timer.
    logic [TW-1:0] startCnt_q; // Time since start-up began.
    logic [GW-1:0] gain_q; // Soft-start amplitude gain.
    logic swap_q; // Exchanges the two cells each carrier period.
    logic [`FLGP_NFAULT-1:0] cause_q; // Sticky fault causes.
    logic bypass_q; // Inrush bypass switch drive.
    logic done_q; // Start-up complete.
    logic [2:0] code_q; // Registered switching state.
    logic [2:0] level_q; // Registered output level.
    logic chg_q; // Capacitors charging.
    logic dis_q; // Capacitors discharging.
    logic byp_q; // Capacitors bypassed.
    logic [CW-1:0] carA; // Carrier A, used by cell one while swap_q is low.
    logic [CW-1:0] carB; // Carrier B, used by cell two while swap_q is low.
    logic valley; // Carrier A valley pulse.
    logic [`FLGP_NSIG-1:0] gateHi; // True gate drives.
    logic [`FLGP_NSIG-1:0] gateLo; // Complement gate drives.

    // ****************
    // Decoding
    // ****************

    // Live trip sources, in cause-bit order.
    wire [`FLGP_NFAULT-1:0] tripNow = {
        (state_q != flgp_pkg::ST_RUN) && (state_q != flgp_pkg::ST_IDLE)
            && (state_q != flgp_pkg::ST_FAULT) && (startCnt_q == START_LAST),
        outputShortTrip, outputOverloadTrip,
        inputOvervoltTrip, inputUndervoltTrip
    };
    wire anyTrip = |tripNow;
    wire switching = (state_q == flgp_pkg::ST_RAMP) || (state_q == flgp_pkg::ST_RUN);
    wire gatesOff = !switching || anyTrip;
    wire lineWrap = (lineCnt_q == LINE_LAST);
    wire preDone = (state_q == flgp_pkg::ST_PRECHARGE) && (seqCnt_q == PRE_LAST);
    wire stepDue = (state_q == flgp_pkg::ST_RAMP) && (seqCnt_q == STEP_LAST);
    wire rampDone = (gain_q == `FLGP_GAIN_FULL);

    // Soft-start scaling of the modulation magnitude.
    wire [PW-1:0] product = dutyMag * gain_q;
    wire [CW-1:0] modValue = product[`FLGP_GAIN_SHIFT +: CW];

    wire cmpA = switching && (modValue > carA);
    wire cmpB = switching && (modValue > carB);
    wire cellOne = swap_q ? cmpB : cmpA;
    wire cellTwo = swap_q ? cmpA : cmpB;
    wire polReq = switching && polarity_q;
    wire [2:0] code = {polReq, cellOne, cellTwo};
    wire [`FLGP_NSIG-1:0] sigReq = {cellTwo, cellOne, polReq};

    wire [2:0] level = (code == `FLGP_SS_FULL_POS) ? `FLGP_LVL_P2 :
        (code == `FLGP_SS_POS_CHG || code == `FLGP_SS_POS_DIS) ? `FLGP_LVL_P1 :
        (code == `FLGP_SS_NEG_DIS || code == `FLGP_SS_NEG_CHG) ? `FLGP_LVL_N1 :
        (code == `FLGP_SS_FULL_NEG) ? `FLGP_LVL_N2 : `FLGP_LVL_Z;
    wire posChg = (code == `FLGP_SS_POS_CHG);
    wire posDis = (code == `FLGP_SS_POS_DIS);
    wire negDis = (code == `FLGP_SS_NEG_DIS);
    wire negChg = (code == `FLGP_SS_NEG_CHG);
    wire bypassCap = !(posChg || posDis || negDis || negChg);

    // ****************
    // Sequencer
    // ****************

    // Start-up walks precharge, ramp and run; any trip latches a fault.
    always_comb begin
        state_d = state_q;
        case (state_q)
            flgp_pkg::ST_IDLE: begin
                if (runEnable && !anyTrip) begin
                    state_d = flgp_pkg::ST_PRECHARGE;
                end
            end
            flgp_pkg::ST_PRECHARGE: begin
                if (preDone) begin
                    state_d = flgp_pkg::ST_RAMP;
                end
            end
            flgp_pkg::ST_RAMP: begin
                if (rampDone) begin
                    state_d = flgp_pkg::ST_RUN;
                end
            end
            flgp_pkg::ST_RUN: begin
                state_d = flgp_pkg::ST_RUN;
            end
            flgp_pkg::ST_FAULT: begin
                // A fault stays until software clears it with the cause gone.
                if (faultClear && !anyTrip) begin
                    state_d = flgp_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = flgp_pkg::ST_FAULT;
            end
        endcase
        if (anyTrip) begin
            state_d = flgp_pkg::ST_FAULT;
        end else if (!runEnable && state_q != flgp_pkg::ST_FAULT) begin
            state_d = flgp_pkg::ST_IDLE;
        end
    end

    // State register and sticky causes; a new trip wins over a clear.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= flgp_pkg::ST_IDLE;
            cause_q <= '0;
        end else begin
            state_q <= state_d;
            if (faultClear && !anyTrip) begin
                cause_q <= '0;
            end else begin
                cause_q <= cause_q | tripNow;
            end
        end
    end

    // start-up time limit
    // The watchdog counts from leaving idle; missing run in time is a fault.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            startCnt_q <= '0;
        end else if (state_q == flgp_pkg::ST_IDLE || state_q == flgp_pkg::ST_RUN) begin
            startCnt_q <= '0;
        end else if (startCnt_q != START_LAST) begin
            startCnt_q <= startCnt_q + TW'(1);
        end
    end

    // Precharge timer, then the soft-start gain ramp.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seqCnt_q <= '0;
            gain_q <= '0;
        end else if (!switching && state_q != flgp_pkg::ST_PRECHARGE) begin
            seqCnt_q <= '0;
            gain_q <= '0;
        end else if (preDone || stepDue) begin
            seqCnt_q <= '0;
            if (state_q == flgp_pkg::ST_RAMP && !rampDone) begin
                gain_q <= gain_q + GW'(1);
            end
        end else begin
            seqCnt_q <= seqCnt_q + TW'(1);
        end
    end

    // ****************
    // Polarity and cell alternation
    // ****************

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineCnt_q <= '0;
            polarity_q <= 1'b0;
        end else if (!switching) begin
            lineCnt_q <= '0;
            polarity_q <= 1'b1;
        end else if (lineWrap) begin
            lineCnt_q <= '0;
            polarity_q <= !polarity_q;
        end else begin
            lineCnt_q <= lineCnt_q + TW'(1);
        end
    end

    // swap cells each period
    // Swapping at the valley keeps both members of each redundant pair in
    // equal use even when the two carriers' comparators are mismatched.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swap_q <= 1'b0;
        end else if (valley) begin
            swap_q <= !swap_q;
        end
    end

    // ****************
    // Carriers and gate drives
    // ****************

    flgp_carrier u_carrier (
        .clk(clk),
        .rst_n(rst_n),
        .halfCfg(swHalfPeriod),
        .carA(carA),
        .carB(carB),
        .valley_q(valley)
    );

    genvar gi;
    generate
        for (gi = 0; gi < `FLGP_NSIG; gi++) begin : g_pair
            flgp_dead_time u_dt (
                .clk(clk),
                .rst_n(rst_n),
                .req(sigReq[gi]),
                .forceOff(gatesOff),
                .deadCfg(deadTime),
                .gate_q(gateHi[gi]),
                .gateN_q(gateLo[gi])
            );
        end
    endgenerate

    assign linePolarityPwm = gateHi[0];
    assign linePolarityPwmN = gateLo[0];
    assign hfCellOnePwm = gateHi[1];
    assign hfCellOnePwmN = gateLo[1];
    assign hfCellTwoPwm = gateHi[2];
    assign hfCellTwoPwmN = gateLo[2];

    // ****************
    // Inrush bypass and status
    // ****************

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            bypass_q <= switching && !anyTrip;
            done_q <= (state_q == flgp_pkg::ST_RUN) && !anyTrip;
        end
    end

    // State code and capacitor direction, one cycle after the request.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= `FLGP_SS_FULL_NEG;
            level_q <= `FLGP_LVL_Z;
            chg_q <= 1'b0;
            dis_q <= 1'b0;
            byp_q <= 1'b1;
        end else begin
            code_q <= code;
            level_q <= switching ? level : `FLGP_LVL_Z;
            chg_q <= posChg || negChg;
            dis_q <= posDis || negDis;
            byp_q <= bypassCap;
        end
    end

    assign inrushBypassSwitch = bypass_q;
    assign switchState = code_q;
    assign outputLevel = level_q;
    assign capCharging = chg_q;
    assign capDischarging = dis_q;
    assign capBypassed = byp_q;
    assign startupDone = done_q;
    assign faultLatched = (state_q == flgp_pkg::ST_FAULT);
    assign faultCause = cause_q;

endmodule

// *** logic/flgp_cfg.svh ***
`ifndef FLGP_CFG_SVH
`define FLGP_CFG_SVH

// ****************
// Clock and timing figures
// ****************

// System clock rate in Hz.
`define FLGP_CLK_HZ 125000000
// Output line frequency in Hz.
`define FLGP_LINE_HZ 60
// Half-cycles per line period.
`define FLGP_HALVES 2
// Milliseconds per second.
`define FLGP_MS_PER_S 1000
// Longest start-up time to nominal output, in ms.
`define FLGP_STARTUP_MS 500
// Inrush precharge time through the resistor, in ms.
`define FLGP_PRECHARGE_MS 100
// Soft-start ramp time of the modulation amplitude, in ms.
`define FLGP_RAMP_MS 300
// Highest and lowest cell switching frequency, in Hz.
`define FLGP_FSW_MAX_HZ 20000
`define FLGP_FSW_MIN_HZ 16000

// ****************
// Widths and field values
// ****************

// Timer width, wide enough for the start-up time.
`define FLGP_TMR_W 27
// Carrier and modulation width.
`define FLGP_CAR_W 12
// Dead-time count width.
`define FLGP_DT_W 8
// Soft-start gain width and its full-scale value.
`define FLGP_GAIN_W 9
`define FLGP_GAIN_FULL 9'h100
// Gain fraction bits dropped after the product.
`define FLGP_GAIN_SHIFT 8
// Number of independent gate signals.
`define FLGP_NSIG 3
// Number of fault causes.
`define FLGP_NFAULT 5

// ****************
// Switching state codes {polarity, cell one, cell two}
// ****************

`define FLGP_SS_FULL_POS 3'h7
`define FLGP_SS_POS_CHG 3'h6
`define FLGP_SS_POS_DIS 3'h5
`define FLGP_SS_ZERO_P 3'h4
`define FLGP_SS_ZERO_N 3'h3
`define FLGP_SS_NEG_DIS 3'h2
`define FLGP_SS_NEG_CHG 3'h1
`define FLGP_SS_FULL_NEG 3'h0

// Output level codes, two's complement, in units of half the bus.
`define FLGP_LVL_P2 3'h2
`define FLGP_LVL_P1 3'h1
`define FLGP_LVL_Z 3'h0
`define FLGP_LVL_N1 3'h7
`define FLGP_LVL_N2 3'h6

`endif

// *** logic/flgp_pkg.sv ***
// ****************
// Shared types
// ****************

package flgp_pkg;

    // Sequencer states of the gate pattern generator.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PRECHARGE,
        ST_RAMP,
        ST_RUN,
        ST_FAULT
    } flgp_state_t;

endpackage

// *** logic/flgp_carrier.sv ***
`timescale 1ns/1ps
`include "flgp_cfg.svh"

// ****************
// Triangular carrier pair, 180 degrees apart
// ****************

module flgp_carrier (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Requested carrier half period in cycles.
    input wire logic [`FLGP_CAR_W-1:0] halfCfg,
    // Carrier A, carrier B and a pulse at the valley of carrier A.
    output logic [`FLGP_CAR_W-1:0] carA,
    output logic [`FLGP_CAR_W-1:0] carB,
    output logic valley_q
);

    localparam int CW = `FLGP_CAR_W;
    // Half periods for the fastest and slowest switching rates.
    localparam logic [CW-1:0] HALF_MIN =
        CW'(`FLGP_CLK_HZ / (`FLGP_HALVES * `FLGP_FSW_MAX_HZ));
    localparam logic [CW-1:0] HALF_MAX =
        CW'(`FLGP_CLK_HZ / (`FLGP_HALVES * `FLGP_FSW_MIN_HZ));

    logic [CW-1:0] cnt_q; // Carrier A count.
    logic upDir_q; // Counting up when high.
    logic [CW-1:0] half_q; // Half period in use.

    // Clamp the request into the allowed switching band.
    wire [CW-1:0] halfClamped = (halfCfg < HALF_MIN) ? HALF_MIN :
                                (halfCfg > HALF_MAX) ? HALF_MAX : halfCfg;
    wire turnDown = upDir_q && (cnt_q >= half_q - CW'(1));
    wire turnUp = !upDir_q && (cnt_q <= CW'(1));

    // Carrier B is carrier A mirrored, which is the half-period shift.
    assign carA = cnt_q;
    assign carB = half_q - cnt_q;

    // Up/down counter; a new period is taken only at the valley so that
    // a change of switching rate never leaves a runt pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            upDir_q <= 1'b1;
            half_q <= HALF_MAX;
            valley_q <= 1'b0;
        end else begin
            valley_q <= turnUp;
            if (turnDown) begin
                upDir_q <= 1'b0;
            end else if (turnUp) begin
                upDir_q <= 1'b1;
                half_q <= halfClamped;
            end
            cnt_q <= upDir_q ? cnt_q + CW'(1) : cnt_q - CW'(1);
        end
    end

endmodule

// *** logic/flgp_dead_time.sv ***
`timescale 1ns/1ps
`include "flgp_cfg.svh"

// ****************
// Complementary gate pair with dead time
// ****************

module flgp_dead_time (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Requested level and forced shutdown.
    input wire logic req,
    input wire logic forceOff,
    // Dead time in cycles.
    input wire logic [`FLGP_DT_W-1:0] deadCfg,
    // True and complement gate drives.
    output logic gate_q,
    output logic gateN_q
);

    logic applied_q; // Level last taken from the request.
    logic [`FLGP_DT_W-1:0] cnt_q; // Remaining dead cycles.

    wire change = (req != applied_q);
    wire settled = (cnt_q == '0) && !change;

    // Any change drops both drives for at least one cycle and then for the
    // programmed count, so the pair can never overlap even with zero set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            applied_q <= 1'b0;
            cnt_q <= '0;
            gate_q <= 1'b0;
            gateN_q <= 1'b0;
        end else if (forceOff) begin
            applied_q <= req;
            cnt_q <= deadCfg;
            gate_q <= 1'b0;
            gateN_q <= 1'b0;
        end else if (change) begin
            applied_q <= req;
            cnt_q <= deadCfg;
            gate_q <= 1'b0;
            gateN_q <= 1'b0;
        end else if (!settled) begin
            cnt_q <= cnt_q - `FLGP_DT_W'(1);
        end else begin
            gate_q <= applied_q;
            gateN_q <= !applied_q;
        end
    end

endmodule

// *** verif/flgp_gate_pattern_gen_asserts.sv ***
`timescale 1ns/1ps
// ****************
// Port checker of the gate pattern generator
// ****************
module flgp_gate_pattern_gen_asserts #(
    parameter int unsigned LINE_HALF_CYC = 64
) (
    // Clock, reset and inputs.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic runEnable,
    input wire logic inputUndervoltTrip,
    input wire logic inputOvervoltTrip,
    input wire logic outputOverloadTrip,
    input wire logic outputShortTrip,
    // Outputs.
    input wire logic linePolarityPwm,
    input wire logic linePolarityPwmN,
    input wire logic hfCellOnePwm,
    input wire logic hfCellOnePwmN,
    input wire logic hfCellTwoPwm,
    input wire logic hfCellTwoPwmN,
    input wire logic inrushBypassSwitch,
    input wire logic [2:0] switchState,
    input wire logic [2:0] outputLevel,
    input wire logic capCharging,
    input wire logic capDischarging,
    input wire logic capBypassed,
    input wire logic startupDone,
    input wire logic faultLatched,
    input wire logic [4:0] faultCause
);
    // Six drives and the bypass in one word.
    wire [6:0] drives = {linePolarityPwm, linePolarityPwmN, hfCellOnePwm, hfCellOnePwmN,
        hfCellTwoPwm, hfCellTwoPwmN, inrushBypassSwitch};
    wire anyTrip = inputUndervoltTrip | inputOvervoltTrip | outputOverloadTrip | outputShortTrip;
    logic [31:0] polCnt_q;
    logic polOld_q;
    logic armed_q;
    wire polMove = switchState[2] != polOld_q;
    // Counts cycles between polarity moves; armed only after a move while running.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            polCnt_q <= 32'h0;
            polOld_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            polCnt_q <= polMove ? 32'h0 : polCnt_q + 32'h1;
            polOld_q <= switchState[2];
            armed_q <= startupDone && (armed_q || polMove);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_pair_excl: assert property (
        !(linePolarityPwm && linePolarityPwmN) && !(hfCellOnePwm && hfCellOnePwmN)
        && !(hfCellTwoPwm && hfCellTwoPwmN)) else $error("gate pair both high");
    a_fault_quiet: assert property (faultLatched |-> drives == 7'h00)
        else $error("drive active in fault");
    a_trip_stop: assert property (anyTrip && startupDone |=> faultLatched && drives == 7'h00)
        else $error("trip did not stop switching");
    a_cause_kept: assert property (faultLatched |-> faultCause != 5'h00)
        else $error("fault without cause");
    a_level_legal: assert property (outputLevel inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7})
        else $error("illegal output level");
    a_cap_onehot: assert property ($onehot({capCharging, capDischarging, capBypassed}))
        else $error("capacitor flags not one-hot");
    a_pol_period: assert property (
        runEnable && startupDone && armed_q && polMove |-> polCnt_q == LINE_HALF_CYC - 1)
        else $error("polarity half-cycle length");
    a_dead_pol: assert property ($rose(linePolarityPwm) |-> !$past(linePolarityPwmN)
        && !$past(linePolarityPwmN, 2)) else $error("polarity dead time missing");
    a_dead_cell: assert property ($rose(hfCellOnePwm) |-> !$past(hfCellOnePwmN)
        && !$past(hfCellOnePwmN, 2)) else $error("cell dead time missing");
    a_bypass_run: assert property (startupDone |-> inrushBypassSwitch)
        else $error("bypass open while running");
endmodule
bind flgp_gate_pattern_gen flgp_gate_pattern_gen_asserts #(.LINE_HALF_CYC(LINE_HALF_CYC)) chk (
    .clk, .rst_n, .runEnable, .inputUndervoltTrip, .inputOvervoltTrip, .outputOverloadTrip,
    .outputShortTrip, .linePolarityPwm, .linePolarityPwmN, .hfCellOnePwm, .hfCellOnePwmN,
    .hfCellTwoPwm, .hfCellTwoPwmN, .inrushBypassSwitch, .switchState, .outputLevel,
    .capCharging, .capDischarging, .capBypassed, .startupDone, .faultLatched, .faultCause);

// *** verif/flgp_gate_drivers.sv ***
`timescale 1ns/1ps
// ****************
// Isolated gate driver and bridge model
// ****************
module flgp_gate_drivers (
    // Clock and gates {pol, polN, one, oneN, two, twoN}.
    input wire logic clk,
    input wire logic [5:0] gates,
    // Bridge level in half-bus units, overlap and cell edge counts.
    output int vab,
    output int shoot,
    output int edges
);
    int va;
    int vb;
    logic oneOld = 1'b0;
    // Leg a runs on true gates, leg b on complements, so legs sit half a cycle apart.
    always_comb begin
        va = 2 * gates[5] + gates[3] + gates[1];
        vb = 2 * gates[4] + gates[2] + gates[0];
        vab = (va - vb) / 2;
    end
    // A pair with both switches on would short the bus, so it is counted.
    always @(posedge clk) begin
        if ((gates[5] && gates[4]) || (gates[3] && gates[2]) || (gates[1] && gates[0]))
            shoot <= shoot + 1;
        if (gates[3] && !oneOld)
            edges <= edges + 1;
        oneOld <= gates[3];
    end
endmodule

// *** verif/flgp_gate_pattern_gen_bench.sv ***
`timescale 1ns/1ps
// ****************
// Self-checking bench of the gate pattern generator
// ****************
module flgp_gate_pattern_gen_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic runEnable = 1'b0;
    logic faultClear = 1'b0;
    logic watch = 1'b0;
    logic [11:0] dutyMag = 12'h000;
    logic [11:0] swHalfPeriod = 12'hC35;
    logic [7:0] deadTime = 8'h04;
    logic [3:0] trip = 4'h0;
    logic [2:0] ss, lvl;
    logic [2:0] ssOld = 3'h0;
    logic [4:0] cause;
    logic byp, done, flt;
    wire [5:0] g;
    wire [2:0] cf;
    int vab, shoot, edges, e0, stab, error_cnt, n_compared;
    int seen[8];
    integer seed = 32'had3d;
    always #4 clk = ~clk;
    flgp_gate_pattern_gen #(.LINE_HALF_CYC(2500), .PRECHARGE_CYC(20), .RAMP_STEP_CYC(2),
        .STARTUP_CYC(20000)) dut (
        .clk, .rst_n, .runEnable, .faultClear, .dutyMag, .swHalfPeriod, .deadTime,
        .inputUndervoltTrip(trip[0]), .inputOvervoltTrip(trip[1]),
        .outputOverloadTrip(trip[2]), .outputShortTrip(trip[3]),
        .linePolarityPwm(g[5]), .linePolarityPwmN(g[4]), .hfCellOnePwm(g[3]),
        .hfCellOnePwmN(g[2]), .hfCellTwoPwm(g[1]), .hfCellTwoPwmN(g[0]),
        .inrushBypassSwitch(byp), .switchState(ss), .outputLevel(lvl), .capCharging(cf[2]),
        .capDischarging(cf[1]), .capBypassed(cf[0]), .startupDone(done), .faultLatched(flt),
        .faultCause(cause));
    flgp_gate_drivers drv (.clk, .gates(g), .vab, .shoot, .edges);
    // Level of a state code, in half-bus units.
    function automatic logic [2:0] lvlOf(input logic [2:0] s);
        case (s)
            3'h7: return 3'h2;
            3'h6, 3'h5: return 3'h1;
            3'h4, 3'h3: return 3'h0;
            3'h2, 3'h1: return 3'h7;
            default: return 3'h6;
        endcase
    endfunction
    // Capacitor flags {charging, discharging, bypassed} of a state code.
    function automatic logic [2:0] capOf(input logic [2:0] s);
        return (s == 3'h6 || s == 3'h1) ? 3'h4 : (s == 3'h5 || s == 3'h2) ? 3'h2 : 3'h1;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Starts the sequencer and waits for the run state under a bound.
    task automatic start();
        int n;
        runEnable <= 1'b1;
        for (n = 0; n < 20000 && done !== 1'b1; n++)
            @(posedge clk);
        check("startupTime", 1, n >= 532 && n < 20000);
        if (n == 20000)
            end_of_test();
        @(negedge clk);
        check("bypass", 1, byp);
    endtask
    // Once a state has settled past the dead time, level, flags and bridge must agree.
    always @(negedge clk) begin
        stab = (ss === ssOld) ? stab + 1 : 0;
        ssOld = ss;
        if (watch && stab == 8) begin
            seen[ss]++;
            check("outputLevel", lvlOf(ss), lvl);
            check("capFlags", capOf(ss), cf);
            check("bridgeLevel", int'($signed(lvlOf(ss))), vab);
        end
    end
    initial begin
        @(negedge clk);
        check("resetDrives", 0, {g, byp, ss, lvl});
        check("resetCapFlags", 1, cf);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        $display("test reset done");
        for (int ph = 0; ph < 2; ph++) begin
            @(posedge clk);
            dutyMag <= (ph ? 12'h900 : 12'h300) + 12'($unsigned($random(seed)) % 512);
            swHalfPeriod <= 12'hC35 + 12'($unsigned($random(seed)) % 782);
            deadTime <= 8'h01 + 8'($unsigned($random(seed)) % 6);
            start();
            e0 = edges;
            watch = 1'b1;
            repeat (24000) @(posedge clk);
            watch = 1'b0;
            check("cellRate", 1, (edges - e0) inside {[2:8]});
            check("shootThrough", 0, shoot);
            runEnable <= 1'b0;
            repeat (4) @(posedge clk);
            $display("test run %0d done", ph);
        end
        for (int i = 0; i < 4; i++) begin
            start();
            @(posedge clk);
            trip[i] <= 1'b1;
            repeat (3) @(posedge clk);
            @(negedge clk);
            check("faultCause", 5'h01 << i, {flt, cause} ^ 6'h20);
            check("faultDrives", 0, {g, byp});
            @(posedge clk);
            faultClear <= 1'b1;
            runEnable <= 1'b0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            check("clearRefused", 1, flt);
            @(posedge clk);
            trip[i] <= 1'b0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            check("cleared", 0, {flt, cause});
            @(posedge clk);
            faultClear <= 1'b0;
            $display("test trip %0d done", i);
        end
        for (int s = 0; s < 8; s++)
            check("stateSeen", 1, seen[s] > 0);
        end_of_test();
    end
endmodule
